// ==== core/soi_pkg.sv ====
// Shared constants, types and helpers for the option, id and stop block
package soi_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [15:0] IDX_OPT2 = 16'h1803;
  localparam logic [15:0] IDX_PID_HI = 16'h1806;
  localparam logic [15:0] IDX_PID_LO = 16'h1807;
  localparam logic [15:0] IDX_STOP = 16'h180d;
  localparam logic [15:0] IDX_WDOG = 16'h1810;
  localparam logic [15:0] IDX_IRQ_ST = 16'h1811;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h1812;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int WD_SEL_LSB = 4;
  localparam int CH0_SEL_BIT = 3;
  localparam int DIV8_BIT = 2;
  localparam int BUS_DIV_LSB = 0;
  localparam int REV_LSB = 4;
  localparam int WD_SRC_BIT = 0;
  localparam logic [7:0] OPT2_RST = 8'h70;
  localparam logic [2:0] WD_SEL_RST = 3'h7;
  localparam logic [1:0] BUS_DIV_RST = 2'h0;
  localparam logic [5:0] WAKE_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // Watchdog, timer and clock divider figures
  // ------------------------------------------------------------
  localparam int WD_LFO_EXP_BASE = 5;
  localparam int WD_LFO_EXP_MAX = 11;
  localparam int WD_BUS_EXP_BASE = 13;
  localparam int WD_BUS_EXP_MAX = 17;
  localparam logic [1:0] TMR_HALF_LAST = 2'h3;
  localparam logic [4:0] CORE_DIV_BASE = 5'h02;
  localparam int SRC_CLK_MHZ = 16;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] wd_sel;
    logic ch0_sel;
    logic div8_en;
    logic [1:0] bus_div;
  } soi_opt2_t;

  typedef struct packed {
    logic keyboard_wake_flag;
    logic ext_irq_wake_flag;
    logic free_counter_wake_flag;
    logic periodic_wake_flag;
    logic lf_receiver_wake_flag;
    logic rf_wake_flag;
  } soi_wake_t;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] addr_of(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction : addr_of

  function automatic logic [17:0] wd_count(input logic [2:0] sel,
                                           input logic bus_src);
    logic [4:0] e;
    e = 5'(WD_LFO_EXP_BASE) + {2'b00, sel};
    // Low-freq source tops out at the reset code's count
    if (e > 5'(WD_LFO_EXP_MAX)) begin
      e = 5'(WD_LFO_EXP_MAX);
    end
    if (bus_src) begin
      e = 5'(WD_BUS_EXP_BASE) + ((sel > 3'h4) ? 5'h04 : {2'b00, sel});
      if (e > 5'(WD_BUS_EXP_MAX)) begin
        e = 5'(WD_BUS_EXP_MAX);
      end
    end
    return 18'h00001 << e;
  endfunction : wd_count

  function automatic logic [4:0] core_div(input logic [1:0] sel);
    return CORE_DIV_BASE << sel;
  endfunction : core_div

endpackage : soi_pkg

// ==== core/soi_sync3.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module soi_sync3 #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire [W-1:0] agree = ~(s2_q ^ s3_q);
  wire [W-1:0] out_d = (s3_q & agree) | (out_q & ~agree);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule : soi_sync3

// ==== core/soi_div8.sv ====
// Divide-by-8 of a sampled clock level
`timescale 1ns/1ps
module soi_div8 (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic level_in,
  output logic div_out
);
  logic prev_q;
  logic [1:0] cnt_q;
  logic div_q;
  wire rise = level_in & ~prev_q;
  // Toggle every fourth rising edge
  wire wrap = rise & (cnt_q == soi_pkg::TMR_HALF_LAST);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      prev_q <= 1'b0;
      cnt_q <= 2'h0;
      div_q <= 1'b0;
    end else begin
      prev_q <= level_in;
      cnt_q <= rise ? cnt_q + 2'h1 : cnt_q;
      div_q <= wrap ? ~div_q : div_q;
    end
  end

  assign div_out = div_q;
endmodule : soi_div8

// ==== core/soi_top.sv ====
// Option, part id and stop-exit status register block on APB
//
// How it works
// - Write-once watchdog timeout select at bits 6:4
// - Low-freq source: 2^5 to 2^11 counts
// - Bus source: 2^13 to 2^17 counts
// - Timer ch0 from pin or low-freq osc
// - Timer external clock optionally divided by eight
// - Bus divider code selects core divide 2..16
// - Revision nibble in high id bits 7:4
// - Twelve-bit part id across both id bytes
// - Stop-exit status is read-only
// - Stop-exit flags cleared on deepest stop entry
// - One stop-exit flag per wake source
// - Of the two resets, only power-on reset clears stop-exit flags
// - Watchdog clock source: 1 kHz or bus
`timescale 1ns/1ps
module soi_top #(
  parameter logic [3:0] REVISION = 4'h0, // Arbitrary value
  parameter logic [11:0] PART_ID = 12'h5a1 // Arbitrary value
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic port_a_pin2_in,
  input wire logic low_freq_osc_in,
  input wire logic rf_data_clock_in,
  input wire logic stop_entry_in,
  input wire logic [5:0] wake_src_in,
  output logic [2:0] watchdog_timeout_sel_out,
  output logic watchdog_clock_src_out,
  output logic [17:0] watchdog_timeout_count_out,
  output logic timer_ch0_out,
  output logic timer_ext_clk_out,
  output logic [1:0] bus_divider_sel_out,
  output logic [4:0] core_divisor_out,
  output logic [5:0] stop_exit_cause_out,
  output logic irq_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  soi_pkg::soi_opt2_t opt_q;
  soi_pkg::soi_opt2_t opt_d;
  soi_pkg::soi_wake_t stop_q;
  soi_pkg::soi_wake_t stop_d;
  logic wd_written_q;
  logic wd_src_q;
  logic [5:0] ist_q;
  logic [5:0] ist_d;
  logic [5:0] imask_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic ch0_q;
  logic ext_q;
  logic [17:0] wd_cnt_q;
  logic [4:0] core_div_q;
  logic [2:0] pins_s;
  logic div8_clk;

  wire any_rst = reset_in | por_in;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire hit_opt2 = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_OPT2);
  wire hit_pidh = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_PID_HI);
  wire hit_pidl = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_PID_LO);
  wire hit_stop = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_STOP);
  wire hit_wdog = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_WDOG);
  wire hit_ist = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_IRQ_ST);
  wire hit_imask = paddr_in == soi_pkg::addr_of(soi_pkg::IDX_IRQ_MASK);
  wire mapped = hit_opt2 | hit_pidh | hit_pidl | hit_stop | hit_wdog |
                hit_ist | hit_imask;
  wire wr = access & pwrite_in & pstrb_in[0] & mapped;
  wire wr_opt2 = wr & hit_opt2;
  wire wr_wdog = wr & hit_wdog;
  wire wr_imask = wr & hit_imask;
  wire rd_clr = access & ~pwrite_in & hit_ist;

  // Read value, bit 7 of the option register and unused bits stay zero
  wire [7:0] rd_opt2 = {1'b0, opt_q};
  wire [7:0] rd_pidh = {REVISION, PART_ID[11:8]};
  wire [7:0] rd_pidl = PART_ID[7:0];
  wire [7:0] rd_stop = {2'b00, stop_q};
  wire [7:0] rd_val =
    hit_opt2 ? rd_opt2 :
    hit_pidh ? rd_pidh :
    hit_pidl ? rd_pidl :
    hit_stop ? rd_stop :
    hit_wdog ? {7'h00, wd_src_q} :
    hit_ist ? {2'b00, ist_q} :
    hit_imask ? {2'b00, imask_q} : 8'h00;

  assign pready_out = access;
  assign pslverr_out = access & err_q;
  assign prdata_out = rdata_q;

  always_ff @(posedge clock_in) begin
    if (any_rst) begin
      rdata_q <= soi_pkg::RDATA_RST;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite_in ? soi_pkg::RDATA_RST : {24'h000000, rd_val};
      err_q <= ~mapped;
    end
  end

  // ------------------------------------------------------------
  // Option register
  // ------------------------------------------------------------
  always_comb begin
    opt_d = opt_q;
    if (wr_opt2) begin
      if (!wd_written_q) begin
        opt_d.wd_sel = pwdata_in[soi_pkg::WD_SEL_LSB +: 3];
      end
      opt_d.ch0_sel = pwdata_in[soi_pkg::CH0_SEL_BIT];
      opt_d.div8_en = pwdata_in[soi_pkg::DIV8_BIT];
      opt_d.bus_div = pwdata_in[soi_pkg::BUS_DIV_LSB +: 2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (any_rst) begin
      opt_q <= soi_pkg::soi_opt2_t'(soi_pkg::OPT2_RST[6:0]);
      wd_written_q <= 1'b0;
      wd_src_q <= 1'b0;
    end else begin
      opt_q <= opt_d;
      wd_written_q <= wd_written_q | wr_opt2;
      if (wr_wdog) begin
        wd_src_q <= pwdata_in[soi_pkg::WD_SRC_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog period and clock divider
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (any_rst) begin
      wd_cnt_q <= soi_pkg::wd_count(soi_pkg::WD_SEL_RST, 1'b0);
      core_div_q <= soi_pkg::core_div(soi_pkg::BUS_DIV_RST);
    end else begin
      wd_cnt_q <= soi_pkg::wd_count(opt_q.wd_sel, wd_src_q);
      core_div_q <= soi_pkg::core_div(opt_q.bus_div);
    end
  end

  assign watchdog_timeout_sel_out = opt_q.wd_sel;
  assign watchdog_clock_src_out = wd_src_q;
  assign watchdog_timeout_count_out = wd_cnt_q;
  assign bus_divider_sel_out = opt_q.bus_div;
  assign core_divisor_out = core_div_q;

  // ------------------------------------------------------------
  // Timer input routing
  // ------------------------------------------------------------
  soi_sync3 #(
    .W(3)
  ) u_pin_sync (
    .clock_in(clock_in),
    .reset_in(any_rst),
    .async_in({rf_data_clock_in, low_freq_osc_in, port_a_pin2_in}),
    .sync_out(pins_s)
  );

  soi_div8 u_div8 (
    .clock_in(clock_in),
    .reset_in(any_rst),
    .level_in(pins_s[2]),
    .div_out(div8_clk)
  );

  always_ff @(posedge clock_in) begin
    if (any_rst) begin
      ch0_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      ch0_q <= opt_q.ch0_sel ? pins_s[1] : pins_s[0];
      ext_q <= opt_q.div8_en ? div8_clk : pins_s[2];
    end
  end

  assign timer_ch0_out = ch0_q;
  assign timer_ext_clk_out = ext_q;

  // ------------------------------------------------------------
  // Stop-exit flags, kept through all but power-on reset
  // ------------------------------------------------------------
  // Wake in the entry cycle survives the clear
  always_comb begin
    stop_d = stop_entry_in ? soi_pkg::soi_wake_t'(soi_pkg::WAKE_RST)
                           : stop_q;
    stop_d = stop_d | soi_pkg::soi_wake_t'(wake_src_in);
  end

  always_ff @(posedge clock_in) begin
    if (por_in) begin
      stop_q <= soi_pkg::soi_wake_t'(soi_pkg::WAKE_RST);
    end else begin
      stop_q <= stop_d;
    end
  end

  assign stop_exit_cause_out = stop_q;

  // ------------------------------------------------------------
  // Interrupt status, cleared by read of the captured bits only
  // ------------------------------------------------------------
  assign ist_d = (ist_q & ~(rd_clr ? rdata_q[5:0] : 6'h00)) | wake_src_in;

  always_ff @(posedge clock_in) begin
    if (any_rst) begin
      ist_q <= soi_pkg::WAKE_RST;
      imask_q <= soi_pkg::WAKE_RST;
    end else begin
      ist_q <= ist_d;
      if (wr_imask) begin
        imask_q <= pwdata_in[5:0];
      end
    end
  end

  assign irq_out = |(ist_q & imask_q);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (any_rst);

  sequence s_setup(logic hit, logic dir);
    psel_in && !penable_in && hit && pwrite_in == dir;
  endsequence

  sequence s_opt2_write;
    psel_in && penable_in && pwrite_in && pstrb_in[0] && hit_opt2;
  endsequence

  a_wdsel_locked: assert property (
    (wd_written_q and s_opt2_write) |=> $stable(opt_q.wd_sel))
    else $error("watchdog timeout select changed after first write");

  a_wdsel_first: assert property (
    (!wd_written_q and s_opt2_write) |=>
      opt_q.wd_sel == $past(pwdata_in[6:4]))
    else $error("first timeout select write not taken");

  a_wd_lfo_count: assert property (
    (!wd_src_q && $stable(opt_q) && $stable(wd_src_q)) |=>
      wd_cnt_q == (($past(opt_q.wd_sel) == 3'h7) ? 18'h00800 :
                   (18'h00020 << $past(opt_q.wd_sel))))
    else $error("low-freq watchdog count wrong");

  a_wd_bus_count: assert property (
    (wd_src_q && opt_q.wd_sel == 3'h0 && $stable(wd_src_q)) |=>
      wd_cnt_q == 18'h02000)
    else $error("bus watchdog count wrong");

  a_wd_src_write: assert property (
    (access && pwrite_in && pstrb_in[0] && hit_wdog) |=>
      wd_src_q == $past(pwdata_in[0]))
    else $error("watchdog clock source not updated");

  a_ch0_route: assert property (
    ##1 timer_ch0_out == ($past(opt_q.ch0_sel) ? $past(pins_s[1])
                                               : $past(pins_s[0])))
    else $error("timer channel 0 routed from wrong source");

  a_ext_direct: assert property (
    (!opt_q.div8_en) |=> timer_ext_clk_out == $past(pins_s[2]))
    else $error("undivided timer clock wrong");

  a_core_div: assert property (
    (opt_q.bus_div == 2'h3 && $stable(opt_q.bus_div)) |=>
      core_divisor_out == 5'h10)
    else $error("core divisor wrong");

  a_id_read: assert property (
    s_setup(hit_pidl, 1'b0) ##1 access |->
      prdata_out == {24'h000000, PART_ID[7:0]})
    else $error("low id byte read wrong");

  a_rev_read: assert property (
    s_setup(hit_pidh, 1'b0) ##1 access |->
      prdata_out[7:4] == REVISION && prdata_out[31:8] == 24'h000000)
    else $error("revision field read wrong");

  a_opt_unused: assert property (
    s_setup(hit_opt2, 1'b0) |=> prdata_out[31:7] == 25'h0000000)
    else $error("unimplemented option bits not zero");

  a_stop_clear: assert property (
    (stop_entry_in && wake_src_in == 6'h00) |=> stop_exit_cause_out == 6'h00)
    else $error("stop flags not cleared on stop entry");

  a_stop_set: assert property (
    (wake_src_in != 6'h00) |=>
      (stop_exit_cause_out & $past(wake_src_in)) == $past(wake_src_in))
    else $error("wake source flag not set");

  a_stop_ro: assert property (
    s_setup(hit_stop, 1'b1) ##1
      (access && !stop_entry_in && wake_src_in == 6'h00)
      |=> $stable(stop_exit_cause_out))
    else $error("stop flags changed by write");

  a_stop_keep: assert property (
    @(posedge clock_in) disable iff (por_in)
    (reset_in && !stop_entry_in && wake_src_in == 6'h00) |=>
      $stable(stop_exit_cause_out))
    else $error("stop flags lost on non power-on reset");

endmodule : soi_top

// ==== verif/soi_top_tb_top.sv ====
// Self-checking bench for the option, part id and stop-exit block
`timescale 1ns/1ps
module soi_top_tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clock_in, reset_in, por_in, psel_in, penable_in, pwrite_in;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd_v;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, err_v, port_a_pin2_in, low_freq_osc_in;
  logic rf_data_clock_in, stop_entry_in, watchdog_clock_src_out;
  logic timer_ch0_out, timer_ext_clk_out, irq_out;
  logic [5:0] wake_src_in, stop_exit_cause_out;
  logic [2:0] watchdog_timeout_sel_out;
  logic [17:0] watchdog_timeout_count_out;
  logic [1:0] bus_divider_sel_out;
  logic [4:0] core_divisor_out;
  int miscompares, n_checks, cnt;

  soi_top dut_u (.clock_in(clock_in), .reset_in(reset_in), .por_in(por_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .port_a_pin2_in(port_a_pin2_in),
    .low_freq_osc_in(low_freq_osc_in), .rf_data_clock_in(rf_data_clock_in),
    .stop_entry_in(stop_entry_in), .wake_src_in(wake_src_in),
    .watchdog_timeout_sel_out(watchdog_timeout_sel_out),
    .watchdog_clock_src_out(watchdog_clock_src_out),
    .watchdog_timeout_count_out(watchdog_timeout_count_out),
    .timer_ch0_out(timer_ch0_out), .timer_ext_clk_out(timer_ext_clk_out),
    .bus_divider_sel_out(bus_divider_sel_out),
    .core_divisor_out(core_divisor_out),
    .stop_exit_cause_out(stop_exit_cause_out), .irq_out(irq_out));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task give_verdict;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cyc

  task apb(input logic w, input logic [15:0] idx, input logic [7:0] d,
           input logic [3:0] st);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= {idx[13:0], 2'b00};
    pwdata_in <= {24'h000000, d};
    pstrb_in <= st;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      give_verdict();
    end
    rd_v = prdata_out;
    err_v = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask : wr

  task rd(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 4'h0);
    check(rd_v, {24'h000000, exp});
  endtask : rd

  task pulse_reset(input logic por);
    @(posedge clock_in);
    reset_in <= 1'b1;
    por_in <= por;
    cyc(2);
    reset_in <= 1'b0;
    por_in <= 1'b0;
  endtask : pulse_reset

  // Counts rising edges of the timer clock over n periods of 16 cycles
  task rf_edges(input int n);
    logic prev;
    prev = timer_ext_clk_out;
    cnt = 0;
    for (int i = 0; i < n * 16; i++) begin
      @(posedge clock_in);
      rf_data_clock_in <= ((i / 8) % 2) == 1;
      if (timer_ext_clk_out === 1'b1 && prev === 1'b0) begin
        cnt++;
      end
      prev = timer_ext_clk_out;
    end
  endtask : rf_edges

  // ------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  initial begin
    #3_000_000;
    miscompares++;
    give_verdict();
  end

  initial begin
    reset_in = 1'b1;
    por_in = 1'b1;
    {psel_in, penable_in, pwrite_in} = 3'b000;
    paddr_in = 16'h0000;
    pwdata_in = 32'h00000000;
    pstrb_in = 4'h0;
    {port_a_pin2_in, low_freq_osc_in, rf_data_clock_in} = 3'b000;
    stop_entry_in = 1'b0;
    wake_src_in = 6'h00;
    miscompares = 0;
    n_checks = 0;
    cyc(20);
    reset_in <= 1'b0;
    por_in <= 1'b0;
    // Reset values, id bytes, read-only and unmapped places
    rd(soi_pkg::IDX_OPT2, 8'h70);
    check(32'(watchdog_timeout_count_out), 32'h00000800);
    check(32'(core_divisor_out), 32'h00000002);
    check(32'(watchdog_clock_src_out), 32'h00000000);
    rd(soi_pkg::IDX_PID_HI, 8'h05);
    rd(soi_pkg::IDX_PID_LO, 8'ha1);
    wr(soi_pkg::IDX_PID_LO, 8'h33);
    rd(soi_pkg::IDX_PID_LO, 8'ha1);
    rd(16'h1900, 8'h00);
    check(32'(err_v), 32'h00000001);
    // Every timeout code from each source, then a refused rewrite
    for (int s = 0; s < 8; s++) begin
      pulse_reset(1'b0);
      wr(soi_pkg::IDX_OPT2, {1'b1, s[2:0], 4'h0});
      cyc(2);
      check(32'(watchdog_timeout_sel_out), 32'(s));
      check(32'(watchdog_timeout_count_out),
            32'h1 << (5 + ((s > 6) ? 6 : s)));
      wr(soi_pkg::IDX_WDOG, 8'h01);
      cyc(2);
      check(32'(watchdog_clock_src_out), 32'h1);
      check(32'(watchdog_timeout_count_out),
            32'h1 << (13 + ((s > 4) ? 4 : s)));
      wr(soi_pkg::IDX_OPT2, {1'b0, ~s[2:0], 4'h0});
      rd(soi_pkg::IDX_OPT2, {1'b0, s[2:0], 4'h0});
    end
    // Clock divider codes; a write with its byte strobe off
    for (int c = 0; c < 4; c++) begin
      wr(soi_pkg::IDX_OPT2, {6'h00, c[1:0]});
      cyc(2);
      check(32'(core_divisor_out), 32'h2 << c);
      check(32'(bus_divider_sel_out), 32'(c));
    end
    apb(1'b1, soi_pkg::IDX_OPT2, 8'hff, 4'he);
    rd(soi_pkg::IDX_OPT2, 8'h73);
    // Timer channel 0 source
    wr(soi_pkg::IDX_OPT2, 8'h00);
    port_a_pin2_in <= 1'b1;
    cyc(8);
    check(32'(timer_ch0_out), 32'h1);
    wr(soi_pkg::IDX_OPT2, 8'h08);
    cyc(8);
    check(32'(timer_ch0_out), 32'h0);
    low_freq_osc_in <= 1'b1;
    cyc(8);
    check(32'(timer_ch0_out), 32'h1);
    // Timer external clock, direct then divided by eight
    rf_edges(8);
    check(32'(cnt >= 7 && cnt <= 9), 32'h1);
    wr(soi_pkg::IDX_OPT2, 8'h04);
    rf_edges(64);
    check(32'(cnt >= 7 && cnt <= 9), 32'h1);
    // Stop-exit flags per wake source, cleared on stop entry
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_in);
      stop_entry_in <= 1'b1;
      @(posedge clock_in);
      stop_entry_in <= 1'b0;
      wake_src_in <= 6'h01 << i;
      @(posedge clock_in);
      wake_src_in <= 6'h00;
      rd(soi_pkg::IDX_STOP, 8'h01 << i);
      check(32'(stop_exit_cause_out), 32'h1 << i);
    end
    wr(soi_pkg::IDX_STOP, 8'hff);
    rd(soi_pkg::IDX_STOP, 8'h20);
    // Interrupt masked, unmasked, then cleared by reading status
    check(32'(irq_out), 32'h0);
    wr(soi_pkg::IDX_IRQ_MASK, 8'h01);
    cyc(2);
    check(32'(irq_out), 32'h1);
    rd(soi_pkg::IDX_IRQ_ST, 8'h3f);
    cyc(2);
    check(32'(irq_out), 32'h0);
    rd(soi_pkg::IDX_IRQ_ST, 8'h00);
    // Of the two resets, only power-on reset clears the stop-exit flags
    pulse_reset(1'b0);
    rd(soi_pkg::IDX_STOP, 8'h20);
    pulse_reset(1'b1);
    rd(soi_pkg::IDX_STOP, 8'h00);
    give_verdict();
  end
endmodule : soi_top_tb_top
